// ### pkg/vrc_pkg.sv
// Package for the video DRAM random-access port controller
package vrc_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int INIT_PAUSE_US = 200;
    localparam int INIT_PAUSE_CYC = (INIT_PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int INIT_STROBES = 8;
    localparam int ROW_PRECHARGE_NS = 70;
    localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_PULSE_NS = 100;
    localparam int ROW_PULSE_CYC = (ROW_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_ACCESS_NS = 25;
    localparam int OE_ACCESS_CYC = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RMW_WE_DELAY_NS = 135;
    localparam int RMW_WE_DELAY_CYC = (RMW_WE_DELAY_NS + CLK_NS - 1) / CLK_NS;
    // Extra column wait so read data clears the pin synchroniser
    localparam int SYNC_CYC = 3;
    localparam int CNT_W = 12;
    // ------------------------------------------------------------
    // Widths and operations
    // ------------------------------------------------------------
    localparam int ADDR_HALF_W = 9;
    localparam int ADDR_W = 2 * ADDR_HALF_W;
    localparam int DATA_W = 8;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RMW = 2'h2;
    localparam logic [1:0] OP_REFRESH = 2'h3;

    typedef struct packed {
        logic [1:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] mask;
        logic use_mask;
        logic keep_page;
    } vrc_req_t;

    typedef struct packed {
        logic row_strobe_n;
        logic col_strobe_n;
        logic mask_or_write_enable_n;
        logic transfer_or_output_enable_n;
        logic serial_shift_clock;
        logic [ADDR_HALF_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } vrc_pins_t;
endpackage : vrc_pkg

// ### verilog/vrc_sync.sv
// Three-stage input synchroniser with agreement filter
module vrc_sync #(
    parameter int W = 8
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    import vrc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } vrc_sync_t;

    vrc_sync_t st_q;
    vrc_sync_t st_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.s1 = D;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Stage one is read only by stage two
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign Q = st_q.q;
endmodule : vrc_sync

// ### verilog/vrc_ctrl.sv
// Host controller for the random-access port of a dual-port video DRAM
module vrc_ctrl (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic USE_REFRESH_INIT,
    input wire logic REQ_VALID,
    input vrc_pkg::vrc_req_t REQ,
    output logic REQ_READY,
    output logic INIT_DONE,
    output logic RDATA_VALID,
    output logic [vrc_pkg::DATA_W-1:0] RDATA,
    output logic ROW_STROBE_N,
    output logic COL_STROBE_N,
    output logic MASK_OR_WRITE_ENABLE_N,
    output logic TRANSFER_OR_OUTPUT_ENABLE_N,
    output logic SERIAL_SHIFT_CLOCK,
    output logic [vrc_pkg::ADDR_HALF_W-1:0] ADDR,
    output logic [vrc_pkg::DATA_W-1:0] MASK_DATA_PINS_OUT,
    output logic MASK_DATA_PINS_OE,
    input wire logic [vrc_pkg::DATA_W-1:0] MASK_DATA_PINS_IN
);
    import vrc_pkg::*;

    typedef enum logic [3:0] {
        S_PAUSE, S_INIT_LOW, S_INIT_HIGH, S_IDLE, S_ROW, S_COL, S_WAIT,
        S_RMW_WE, S_END, S_PRECHARGE
    } vrc_state_t;

    typedef struct packed {
        vrc_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [3:0] init_n;
        logic [1:0] op;
        logic [ADDR_HALF_W-1:0] row;
        logic [ADDR_HALF_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic keep_page;
        vrc_pins_t pins;
        logic ready;
        logic done;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
    } vrc_ctrl_t;

    vrc_ctrl_t st_q;
    vrc_ctrl_t st_d;
    logic [DATA_W-1:0] dq_sync;

    // Pins from the device arrive unclocked
    vrc_sync #(.W(DATA_W)) u_sync (
        .SYS_CLK(SYS_CLK),
        .RESET_N(RESET_N),
        .D(MASK_DATA_PINS_IN),
        .Q(dq_sync)
    );

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction : cyc

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ready = 1'b0;
        st_d.rvalid = 1'b0;
        if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - cyc(1);
        end
        unique case (st_q.state)
            S_PAUSE: begin
                if (st_q.cnt == '0) begin
                    st_d.state = S_INIT_LOW;
                    st_d.pins.col_strobe_n = !USE_REFRESH_INIT;
                    st_d.cnt = cyc(ROW_PULSE_CYC);
                end
            end
            S_INIT_LOW: begin
                // Serial clock toggles with each init strobe
                if (st_q.pins.col_strobe_n == USE_REFRESH_INIT) begin
                    st_d.pins.col_strobe_n = !USE_REFRESH_INIT;
                end else if (st_q.pins.row_strobe_n) begin
                    st_d.pins.row_strobe_n = 1'b0;
                    st_d.pins.serial_shift_clock = 1'b1;
                    // Width counted from the fall, not from state entry
                    st_d.cnt = cyc(ROW_PULSE_CYC);
                end
                if (!st_q.pins.row_strobe_n && st_q.cnt == '0) begin
                    st_d.pins.row_strobe_n = 1'b1;
                    st_d.pins.col_strobe_n = 1'b1;
                    st_d.pins.serial_shift_clock = 1'b0;
                    st_d.init_n = st_q.init_n + 4'h1;
                    st_d.cnt = cyc(ROW_PRECHARGE_CYC);
                    st_d.state = S_INIT_HIGH;
                end
            end
            S_INIT_HIGH: begin
                if (st_q.cnt == '0) begin
                    if (st_q.init_n == 4'(INIT_STROBES)) begin
                        st_d.done = 1'b1;
                        st_d.ready = 1'b1;
                        st_d.state = S_IDLE;
                    end else begin
                        st_d.pins.col_strobe_n = !USE_REFRESH_INIT;
                        st_d.cnt = cyc(ROW_PULSE_CYC);
                        st_d.state = S_INIT_LOW;
                    end
                end
            end
            S_IDLE: begin
                st_d.ready = 1'b1;
                if (REQ_VALID && st_q.ready) begin
                    st_d.ready = 1'b0;
                    st_d.op = REQ.op;
                    st_d.row = REQ.addr[ADDR_W-1:ADDR_HALF_W];
                    st_d.col = REQ.addr[ADDR_HALF_W-1:0];
                    st_d.wdata = REQ.wdata;
                    st_d.keep_page = REQ.keep_page && REQ.op != OP_REFRESH;
                    st_d.pins.addr = REQ.addr[ADDR_W-1:ADDR_HALF_W];
                    if (REQ.op == OP_REFRESH) begin
                        st_d.pins.col_strobe_n = 1'b0;
                        st_d.state = S_ROW;
                    end else begin
                        // Mask rides the pins at the row edge
                        st_d.pins.mask_or_write_enable_n = !(REQ.use_mask && REQ.op != OP_READ);
                        st_d.pins.dq_out = REQ.mask;
                        st_d.pins.dq_oe = REQ.use_mask && REQ.op != OP_READ;
                        st_d.state = S_ROW;
                    end
                end
            end
            S_ROW: begin
                st_d.pins.row_strobe_n = 1'b0;
                st_d.cnt = cyc(ROW_PULSE_CYC);
                st_d.state = (st_q.op == OP_REFRESH) ? S_WAIT : S_COL;
            end
            S_COL: begin
                // Mask is taken; release and present column
                st_d.pins.addr = st_q.col;
                st_d.pins.mask_or_write_enable_n = (st_q.op != OP_WRITE);
                st_d.pins.dq_out = st_q.wdata;
                st_d.pins.dq_oe = (st_q.op == OP_WRITE);
                st_d.pins.transfer_or_output_enable_n = (st_q.op == OP_WRITE);
                st_d.state = S_WAIT;
                // Pin data lags by the synchroniser before it may be taken
                st_d.cnt = cyc(RMW_WE_DELAY_CYC + SYNC_CYC);
            end
            S_WAIT: begin
                if (st_q.op != OP_REFRESH && st_q.pins.row_strobe_n == 1'b0
                    && st_q.pins.col_strobe_n) begin
                    st_d.pins.col_strobe_n = 1'b0;
                end else if (st_q.cnt == '0) begin
                    if (st_q.op == OP_RMW) begin
                        st_d.state = S_RMW_WE;
                    end else begin
                        st_d.state = S_END;
                    end
                end
            end
            S_RMW_WE: begin
                // Read sampled, then write with enable late
                st_d.rdata = dq_sync;
                st_d.rvalid = 1'b1;
                st_d.pins.transfer_or_output_enable_n = 1'b1;
                st_d.pins.dq_out = st_q.wdata;
                st_d.pins.dq_oe = 1'b1;
                st_d.pins.mask_or_write_enable_n = 1'b0;
                st_d.cnt = cyc(OE_ACCESS_CYC);
                st_d.state = S_END;
            end
            S_END: begin
                if (st_q.cnt == '0) begin
                    if (st_q.op == OP_READ) begin
                        // Output valid until column strobe rises
                        st_d.rdata = dq_sync;
                        st_d.rvalid = 1'b1;
                    end
                    st_d.pins.col_strobe_n = 1'b1;
                    st_d.pins.transfer_or_output_enable_n = 1'b1;
                    st_d.pins.dq_oe = 1'b0;
                    st_d.pins.mask_or_write_enable_n = 1'b1;
                    if (st_q.keep_page && REQ_VALID && REQ.op != OP_REFRESH
                        && REQ.addr[ADDR_W-1:ADDR_HALF_W] == st_q.row) begin
                        st_d.op = REQ.op;
                        st_d.col = REQ.addr[ADDR_HALF_W-1:0];
                        st_d.wdata = REQ.wdata;
                        st_d.keep_page = REQ.keep_page;
                        st_d.state = S_COL;
                    end else begin
                        st_d.pins.row_strobe_n = 1'b1;
                        st_d.cnt = cyc(ROW_PRECHARGE_CYC);
                        st_d.state = S_PRECHARGE;
                    end
                end
            end
            S_PRECHARGE: begin
                if (st_q.cnt == '0) begin
                    st_d.ready = 1'b1;
                    st_d.state = S_IDLE;
                end
            end
        endcase
    end

    // Page hits take the request from the END state
    logic page_take;
    assign page_take = st_q.state == S_END && st_d.state == S_COL;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '0;
            st_q.state <= S_PAUSE;
            st_q.cnt <= CNT_W'(INIT_PAUSE_CYC);
            st_q.pins.row_strobe_n <= 1'b1;
            st_q.pins.col_strobe_n <= 1'b1;
            st_q.pins.mask_or_write_enable_n <= 1'b1;
            st_q.pins.transfer_or_output_enable_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REQ_READY = st_q.ready;
    assign INIT_DONE = st_q.done;
    assign RDATA_VALID = st_q.rvalid;
    assign RDATA = st_q.rdata;
    assign ROW_STROBE_N = st_q.pins.row_strobe_n;
    assign COL_STROBE_N = st_q.pins.col_strobe_n;
    assign MASK_OR_WRITE_ENABLE_N = st_q.pins.mask_or_write_enable_n;
    assign TRANSFER_OR_OUTPUT_ENABLE_N = st_q.pins.transfer_or_output_enable_n;
    assign SERIAL_SHIFT_CLOCK = st_q.pins.serial_shift_clock;
    assign ADDR = st_q.pins.addr;
    assign MASK_DATA_PINS_OUT = st_q.pins.dq_out;
    assign MASK_DATA_PINS_OE = st_q.pins.dq_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_init_pause: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !st_q.done |-> $past(st_q.state) != S_IDLE) else $error("idle before init");
    chk_row_precharge: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(ROW_STROBE_N) |=> ROW_STROBE_N) else $error("precharge too short");
    chk_row_min_width: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $fell(ROW_STROBE_N) |=> !ROW_STROBE_N) else $error("row strobe aborted");
    chk_row_before_col: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $fell(ROW_STROBE_N) && st_q.op != OP_REFRESH && st_q.done |-> COL_STROBE_N)
        else $error("column low at row edge");
    chk_read_we_high: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !COL_STROBE_N && st_q.op == OP_READ && st_q.done |-> MASK_OR_WRITE_ENABLE_N)
        else $error("write enable low in read");
    chk_early_write: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $fell(COL_STROBE_N) && st_q.op == OP_WRITE |-> !MASK_OR_WRITE_ENABLE_N && MASK_DATA_PINS_OE)
        else $error("early write setup");
    chk_no_contention: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        MASK_DATA_PINS_OE |-> TRANSFER_OR_OUTPUT_ENABLE_N)
        else $error("bus contention");
    chk_page_row_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        page_take |=> !ROW_STROBE_N ##1 !ROW_STROBE_N) else $error("page row released");
endmodule : vrc_ctrl

// ### dv/vrc_dram_model.sv
// Behavioural model of the video DRAM random-access port
module vrc_dram_model (
    input wire logic row_n,
    input wire logic col_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [vrc_pkg::ADDR_HALF_W-1:0] addr,
    input wire logic [vrc_pkg::DATA_W-1:0] host_dq,
    input wire logic host_oe,
    input wire logic slow,
    output logic [vrc_pkg::DATA_W-1:0] pin,
    output logic [8:0] refresh_row,
    output int viol
);
    timeunit 1ns;
    timeprecision 1ns;
    import vrc_pkg::*;
    // ------------------------------------------------------------
    // Array, latches and pin resolution
    // ------------------------------------------------------------
    logic [7:0] mem [logic [17:0]];
    logic [8:0] row_q;
    logic [17:0] a_q;
    logic [7:0] wmask_q, rdata_q;
    logic [7:0] last_q = 8'h00;
    logic early_q = 1'b0;
    logic valid_q = 1'b0;
    logic drive;
    time t_fall = 0;
    time t_rise = 0;
    initial refresh_row = 9'h000;
    initial viol = 0;

    task automatic store(input logic [7:0] d);
        logic [7:0] old;
        old = mem.exists(a_q) ? mem[a_q] : 8'h00;
        mem[a_q] = (old & ~wmask_q) | (d & wmask_q);
    endtask : store

    assign drive = !col_n && !oe_n && !early_q;

    // No keeper on the pins: a floating bus shows a changing pattern
    always @(host_oe, host_dq, drive, valid_q, rdata_q) begin
        pin = (host_oe && drive) ? 8'hxx : host_oe ? host_dq :
              (drive && valid_q) ? rdata_q : ~last_q;
        last_q = pin;
    end

    // Sampled 1 ns late, since address and strobe leave the same flop edge
    always @(negedge row_n) begin
        t_fall = $time;
        if (t_fall - t_rise < ROW_PRECHARGE_NS) viol++;
        #1;
        if (col_n === 1'b0) begin
            refresh_row = refresh_row + 9'h001;
        end else begin
            row_q = addr;
            wmask_q = we_n ? 8'hff : pin;
        end
    end

    always @(posedge row_n) begin
        if (t_fall > t_rise && $time - t_fall < ROW_PULSE_NS) viol++;
        t_rise = $time;
    end

    always @(negedge col_n) begin
        #1;
        if (row_n === 1'b0) begin
            a_q = {row_q, addr};
            early_q = !we_n;
            rdata_q = mem.exists(a_q) ? mem[a_q] : 8'h00;
            if (early_q) store(pin);
            valid_q = 1'b0;
            #(slow ? 24 : 0);
            valid_q = 1'b1;
        end
    end

    always @(negedge we_n) begin
        #1;
        if (row_n === 1'b0 && col_n === 1'b0 && !early_q) store(pin);
    end
endmodule : vrc_dram_model

// ### dv/tb.sv
// Self-checking testbench of the video DRAM port controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vrc_pkg::*;
    // ------------------------------------------------------------
    // Signals, instances and monitors
    // ------------------------------------------------------------
    localparam logic [17:0] A1 = {9'h1a5, 9'h0c3};
    localparam logic [17:0] A2 = {9'h1a5, 9'h13c};
    localparam logic [17:0] A3 = {9'h055, 9'h1ff};
    logic SYS_CLK, RESET_N, USE_REFRESH_INIT, REQ_VALID, REQ_READY, INIT_DONE, RDATA_VALID;
    logic ROW_STROBE_N, COL_STROBE_N, MASK_OR_WRITE_ENABLE_N, TRANSFER_OR_OUTPUT_ENABLE_N;
    logic SERIAL_SHIFT_CLOCK, MASK_DATA_PINS_OE, slow;
    vrc_req_t REQ;
    logic [DATA_W-1:0] RDATA, MASK_DATA_PINS_OUT, MASK_DATA_PINS_IN;
    logic [ADDR_HALF_W-1:0] ADDR, row_seen, col_seen;
    logic [8:0] refresh_row;
    int viol, n_row, n_col, n_cbr, n_sc;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    time t_first, t_rel;

    vrc_ctrl vrc_ctrl_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
        .USE_REFRESH_INIT(USE_REFRESH_INIT), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .REQ_READY(REQ_READY), .INIT_DONE(INIT_DONE), .RDATA_VALID(RDATA_VALID),
        .RDATA(RDATA), .ROW_STROBE_N(ROW_STROBE_N), .COL_STROBE_N(COL_STROBE_N),
        .MASK_OR_WRITE_ENABLE_N(MASK_OR_WRITE_ENABLE_N),
        .TRANSFER_OR_OUTPUT_ENABLE_N(TRANSFER_OR_OUTPUT_ENABLE_N),
        .SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .ADDR(ADDR),
        .MASK_DATA_PINS_OUT(MASK_DATA_PINS_OUT), .MASK_DATA_PINS_OE(MASK_DATA_PINS_OE),
        .MASK_DATA_PINS_IN(MASK_DATA_PINS_IN));

    vrc_dram_model vrc_dram_model_inst (.row_n(ROW_STROBE_N), .col_n(COL_STROBE_N),
        .we_n(MASK_OR_WRITE_ENABLE_N), .oe_n(TRANSFER_OR_OUTPUT_ENABLE_N), .addr(ADDR),
        .host_dq(MASK_DATA_PINS_OUT), .host_oe(MASK_DATA_PINS_OE), .slow(slow),
        .pin(MASK_DATA_PINS_IN), .refresh_row(refresh_row), .viol(viol));

    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    always @(negedge ROW_STROBE_N) begin
        #1;
        n_row++;
        if (COL_STROBE_N === 1'b0) n_cbr++;
        if (n_row == 1) t_first = $time;
        row_seen = ADDR;
    end

    always @(negedge COL_STROBE_N) begin
        #1;
        n_col++;
        col_seen = ADDR;
    end

    always @(posedge SERIAL_SHIFT_CLOCK) n_sc++;

    // Two init pauses of 2000 cycles dominate the run
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Keeping the page leaves valid high for the caller's follow-up request
    task automatic issue(input logic [1:0] op, input logic [17:0] a, input logic [7:0] wd,
                         input logic [7:0] m, input logic um, input logic kp);
        int i;
        @(posedge SYS_CLK);
        REQ <= '{op: op, addr: a, wdata: wd, mask: m, use_mask: um, keep_page: kp};
        REQ_VALID <= 1'b1;
        for (i = 0; i < 200 && REQ_READY !== 1'b1; i++) @(negedge SYS_CLK);
        check(i < 200, 1);
        @(posedge SYS_CLK);
        if (!kp) REQ_VALID <= 1'b0;
    endtask : issue

    task automatic wait_rd(input logic [7:0] exp);
        int i;
        for (i = 0; i < 100 && RDATA_VALID !== 1'b1; i++) @(negedge SYS_CLK);
        check(i < 100, 1);
        check(RDATA, exp);
    endtask : wait_rd

    task automatic rd(input logic [17:0] a, input logic [7:0] exp);
        issue(OP_READ, a, 8'h00, 8'h00, 1'b0, 1'b0);
        wait_rd(exp);
    endtask : rd

    task automatic do_init(input logic cbr);
        int i;
        @(posedge SYS_CLK);
        RESET_N <= 1'b0;
        USE_REFRESH_INIT <= cbr;
        repeat (4) @(posedge SYS_CLK);
        n_row = 0;
        n_cbr = 0;
        n_sc = 0;
        t_rel = $time;
        RESET_N <= 1'b1;
        for (i = 0; i < 3000 && INIT_DONE !== 1'b1; i++) @(negedge SYS_CLK);
        check(n_row, 8);
        check(INIT_DONE, 1'b1);
        check(n_cbr, cbr ? 8 : 0);
        check(n_sc >= 8, 1);
        check(t_first - t_rel >= 200000, 1);
    endtask : do_init

    task automatic t_basic();
        issue(OP_WRITE, A1, 8'h3c, 8'h00, 1'b0, 1'b0);
        issue(OP_WRITE, A3, 8'hc3, 8'h00, 1'b0, 1'b0);
        issue(OP_WRITE, A2, 8'h96, 8'h00, 1'b0, 1'b0);
        rd(A3, 8'hc3);
        check(row_seen, A3[17:9]);
        check(col_seen, A3[8:0]);
        rd(A1, 8'h3c);
    endtask : t_basic

    task automatic t_mask();
        issue(OP_WRITE, A3, 8'hff, 8'h00, 1'b0, 1'b0);
        issue(OP_WRITE, A3, 8'h00, 8'h0f, 1'b1, 1'b0);
        rd(A3, 8'hf0);
        issue(OP_WRITE, A3, 8'h5a, 8'h00, 1'b0, 1'b0);
        rd(A3, 8'h5a);
    endtask : t_mask

    task automatic t_rmw();
        issue(OP_RMW, A1, 8'h77, 8'h00, 1'b0, 1'b0);
        wait_rd(8'h3c);
        rd(A1, 8'h77);
    endtask : t_rmw

    task automatic t_page();
        int r0;
        int c0;
        int i;
        r0 = n_row;
        c0 = n_col;
        issue(OP_WRITE, A1, 8'he1, 8'h00, 1'b0, 1'b1);
        REQ <= '{op: OP_READ, addr: A2, wdata: 8'h00, mask: 8'h00, use_mask: 1'b0,
                 keep_page: 1'b0};
        for (i = 0; i < 100 && n_col < c0 + 2; i++) @(negedge SYS_CLK);
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b0;
        wait_rd(8'h96);
        check(n_row - r0, 1);
        rd(A1, 8'he1);
    endtask : t_page

    task automatic t_refresh();
        logic [8:0] rr;
        rr = refresh_row;
        issue(OP_REFRESH, 18'h00000, 8'h00, 8'h00, 1'b0, 1'b0);
        slow <= 1'b1;
        rd(A3, 8'h5a);
        check(refresh_row, rr + 9'h001);
        @(posedge SYS_CLK);
        slow <= 1'b0;
    endtask : t_refresh

    initial begin
        RESET_N = 1'b0;
        REQ_VALID = 1'b0;
        REQ = '0;
        USE_REFRESH_INIT = 1'b0;
        slow = 1'b0;
        do_init(1'b1);
        do_init(1'b0);
        t_basic();
        t_mask();
        t_rmw();
        t_page();
        t_refresh();
        check(viol, 0);
        summarize();
    end
endmodule : tb
